// >>> hdl/spi_burst_pkg.sv
package spi_burst_pkg;

  localparam int WORD_W  = 32;
  localparam int LEN_W   = 12;
  localparam int LOW_W   = 5;
  localparam int POS_W   = 6;
  localparam int WCNT_W  = LEN_W - LOW_W;
  localparam int RDCNT_W = 8;
  localparam int SYNC_W  = 4;

  // Sync slots, system side
  localparam int SY_TAKE = 0;
  localparam int SY_RX   = 1;
  localparam int SY_DONE = 2;
  localparam int SY_SS   = 3;
  // Sync slots, link side
  localparam int LS_START = 0;
  localparam int LS_POST  = 1;

  localparam logic [POS_W-1:0]  FULL_WORD = 6'h20;
  localparam logic [POS_W-1:0]  POS_ZERO  = 6'h00;
  localparam logic [POS_W-1:0]  POS_ONE   = 6'h01;
  localparam logic [WCNT_W-1:0] WCNT_ZERO = 7'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0;
  localparam logic [WORD_W-1:0] WORD_ONES = 32'hffffffff;

  typedef struct packed {
    logic             channel_role_select;
    logic             select_line_burst_end;
    logic             auto_start_on_write;
    logic [LEN_W-1:0] burst_bit_count;
  } cfg_s;

  typedef struct packed {
    logic mosi;
    logic miso;
    logic ss_n;
  } spi_in_s;

  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic ss_n;
    logic ss_n_oe;
  } spi_out_s;

  function automatic logic [POS_W-1:0] first_len(input logic [LEN_W-1:0] len);
    return {1'b0, len[LOW_W-1:0]} + POS_ONE;
  endfunction

  function automatic logic [WCNT_W-1:0] words_after(input logic [LEN_W-1:0] len);
    return len[LEN_W-1:LOW_W];
  endfunction

  function automatic logic [WORD_W-1:0] aligned(input logic [WORD_W-1:0] w, input logic [POS_W-1:0] n);
    return w << (FULL_WORD - n);
  endfunction

  function automatic logic [WORD_W-1:0] low_bits(input logic [WORD_W-1:0] w, input logic [POS_W-1:0] n);
    return w & ~(WORD_ONES << n);
  endfunction

endpackage

// >>> hdl/spi_burst_controller.sv
`timescale 1ns/1ps
module spi_burst_controller #(
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8
) (
  input  wire logic                                 clock,
  input  wire logic                                 rstn,
  input  wire logic                                 link_clk,
  input  wire spi_burst_pkg::cfg_s                  cfg,
  input  wire logic                                 exchange_trigger,
  input  wire logic [$clog2(TX_DEPTH):0]            tx_dma_level,
  input  wire logic                                 tx_valid,
  output logic                                      tx_ready,
  input  wire logic [spi_burst_pkg::WORD_W-1:0]     tx_data,
  output logic                                      rx_valid,
  input  wire logic                                 rx_ready,
  output logic [spi_burst_pkg::WORD_W-1:0]          rx_data,
  output logic                                      tx_dma_req,
  output logic                                      busy,
  output logic                                      rx_overflow,
  output logic [spi_burst_pkg::RDCNT_W-1:0]         tx_fifo_read_count,
  input  wire spi_burst_pkg::spi_in_s               spi_in,
  output spi_burst_pkg::spi_out_s                   spi_out
);
  localparam int TP_W = $clog2(TX_DEPTH);
  localparam int RP_W = $clog2(RX_DEPTH);

  typedef struct packed {
    logic [TX_DEPTH-1:0][spi_burst_pkg::WORD_W-1:0] txm;
    logic [TP_W-1:0]                                twp;
    logic [TP_W-1:0]                                trp;
    logic [TP_W:0]                                  tcnt;
    logic [RX_DEPTH-1:0][spi_burst_pkg::WORD_W-1:0] rxm;
    logic [RP_W-1:0]                                rwp;
    logic [RP_W-1:0]                                rrp;
    logic [RP_W:0]                                  rcnt;
    logic [spi_burst_pkg::WORD_W-1:0]               hold;
    logic                                           posted;
    logic                                           post_tgl;
    logic [spi_burst_pkg::SYNC_W-1:0]               s1;
    logic [spi_burst_pkg::SYNC_W-1:0]               s2;
    logic                                           take_seen;
    logic                                           rx_seen;
    logic                                           done_seen;
    logic                                           ss_seen;
    logic                                           start_tgl;
    logic                                           busy;
    logic                                           cap_pend;
    logic                                           ovf;
    logic [spi_burst_pkg::RDCNT_W-1:0]              rdcnt;
    spi_burst_pkg::cfg_s                            cfg;
  } sys_s;

  typedef struct packed {
    logic [1:0]                         sy1;
    logic [1:0]                         sy2;
    logic                               start_seen;
    logic                               take_tgl;
    logic                               rx_tgl;
    logic                               done_tgl;
    logic                               run;
    logic                               need_load;
    logic                               ph;
    logic                               sclk;
    logic                               ssn;
    logic [spi_burst_pkg::POS_W-1:0]    got;
    logic [spi_burst_pkg::POS_W-1:0]    cur_len;
    logic [spi_burst_pkg::WCNT_W-1:0]   wleft;
    logic [spi_burst_pkg::WORD_W-1:0]   tx_sh;
    logic [spi_burst_pkg::WORD_W-1:0]   rx_sh;
    logic [spi_burst_pkg::WORD_W-1:0]   rx_hold;
  } link_s;

  sys_s        s_q, s_d;
  link_s       l_q, l_d;
  logic [1:0]  rst_sync_q;
  logic [1:0]  lrst_sync_q;
  logic        fresh_q;
  logic        rst_n;
  logic        lrst_n;
  logic        frame_clr;
  logic        tx_push, pop_ev, take_ev, rx_ev, done_ev, ss_rise, cap_ok, push_ev, push_ok, rx_pop;
  logic        master, avail, bit_ev;
  logic [spi_burst_pkg::WORD_W-1:0] push_word;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) rst_sync_q <= 2'h0;
    else       rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) lrst_sync_q <= 2'h0;
    else       lrst_sync_q <= {lrst_sync_q[0], 1'b1};
  end
  assign lrst_n = lrst_sync_q[1];

  // System side: queues, hand-off of words, burst start
  always_comb begin
    s_d       = s_q;
    tx_push   = tx_valid && tx_ready;
    s_d.s1    = {spi_in.ss_n, l_q.done_tgl, l_q.rx_tgl, l_q.take_tgl};
    s_d.s2    = s_q.s1;
    take_ev   = s_q.s2[spi_burst_pkg::SY_TAKE] != s_q.take_seen;
    rx_ev     = s_q.s2[spi_burst_pkg::SY_RX] != s_q.rx_seen;
    done_ev   = s_q.s2[spi_burst_pkg::SY_DONE] != s_q.done_seen;
    ss_rise   = s_q.s2[spi_burst_pkg::SY_SS] && !s_q.ss_seen;
    s_d.take_seen = s_q.s2[spi_burst_pkg::SY_TAKE];
    s_d.rx_seen   = s_q.s2[spi_burst_pkg::SY_RX];
    s_d.done_seen = s_q.s2[spi_burst_pkg::SY_DONE];
    s_d.ss_seen   = s_q.s2[spi_burst_pkg::SY_SS];
    if (tx_push) begin
      s_d.txm[s_q.twp] = tx_data;
      s_d.twp          = s_q.twp + 1'b1;
    end
    // Count comes from flops only, so a queue write never disturbs the pop decision
    pop_ev = !s_q.posted && (s_q.tcnt != '0);
    if (pop_ev) begin
      s_d.hold     = s_q.txm[s_q.trp];
      s_d.trp      = s_q.trp + 1'b1;
      s_d.posted   = 1'b1;
      s_d.post_tgl = !s_q.post_tgl;
      s_d.rdcnt    = s_q.rdcnt + 1'b1;
    end
    if (take_ev) s_d.posted = 1'b0;
    s_d.tcnt = s_q.tcnt + (TP_W+1)'(tx_push) - (TP_W+1)'(pop_ev);
    // Partial word after a select-ended burst; one cycle later so a last full word lands first
    cap_ok    = s_q.cap_pend && !rx_ev;
    push_ev   = rx_ev || (cap_ok && (l_q.got != spi_burst_pkg::POS_ZERO));
    push_word = rx_ev ? l_q.rx_hold : spi_burst_pkg::low_bits(l_q.rx_sh, l_q.got);
    push_ok   = push_ev && (s_q.rcnt != (RP_W+1)'(RX_DEPTH));
    rx_pop    = rx_valid && rx_ready;
    if (push_ev && !push_ok) s_d.ovf = 1'b1;
    if (push_ok) begin
      s_d.rxm[s_q.rwp] = push_word;
      s_d.rwp          = s_q.rwp + 1'b1;
    end
    if (rx_pop) s_d.rrp = s_q.rrp + 1'b1;
    s_d.rcnt = s_q.rcnt + (RP_W+1)'(push_ok) - (RP_W+1)'(rx_pop);
    if (cap_ok) s_d.cap_pend = 1'b0;
    if (ss_rise && !s_q.cfg.channel_role_select && s_q.cfg.select_line_burst_end) s_d.cap_pend = 1'b1;
    if (!s_q.busy && s_q.cfg.channel_role_select &&
        (exchange_trigger || (s_q.cfg.auto_start_on_write && (s_q.tcnt != '0)))) begin
      s_d.busy      = 1'b1;
      s_d.start_tgl = !s_q.start_tgl;
    end
    if (done_ev) s_d.busy = 1'b0;
    // Configuration frozen while a master burst runs; link side reads it as static
    if (!s_q.busy) s_d.cfg = cfg;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else        s_q <= s_d;
  end

  assign tx_ready           = s_q.tcnt != (TP_W+1)'(TX_DEPTH);
  assign rx_valid           = s_q.rcnt != '0;
  assign rx_data            = s_q.rxm[s_q.rrp];
  assign tx_dma_req         = s_q.tcnt <= tx_dma_level;
  assign busy               = s_q.busy;
  assign rx_overflow        = s_q.ovf;
  assign tx_fifo_read_count = s_q.rdcnt;

  // Slave frame marker: select high restarts word position; no clock edge is needed for it
  assign frame_clr = !lrst_n || (!s_q.cfg.channel_role_select && spi_in.ss_n);
  always_ff @(posedge link_clk or posedge frame_clr) begin
    if (frame_clr)         fresh_q <= 1'b1;
    else if (!spi_in.ss_n) fresh_q <= 1'b0;
  end

  // Link side: bit engine on the serial clock
  always_comb begin
    logic [spi_burst_pkg::POS_W-1:0]  cl, g1, base_len, next_len;
    logic [spi_burst_pkg::WCNT_W-1:0] wl, base_w, next_w;
    l_d      = l_q;
    cl       = l_q.cur_len;
    g1       = l_q.got;
    wl       = l_q.wleft;
    next_len = spi_burst_pkg::FULL_WORD;
    next_w   = spi_burst_pkg::WCNT_ZERO;
    master   = s_q.cfg.channel_role_select;
    l_d.sy1  = {s_q.post_tgl, s_q.start_tgl};
    l_d.sy2  = l_q.sy1;
    l_d.start_seen = l_q.sy2[spi_burst_pkg::LS_START];
    avail    = l_q.sy2[spi_burst_pkg::LS_POST] != l_q.take_tgl;
    bit_ev   = 1'b0;
    base_len = s_q.cfg.select_line_burst_end ? spi_burst_pkg::FULL_WORD
                                             : spi_burst_pkg::first_len(s_q.cfg.burst_bit_count);
    base_w   = s_q.cfg.select_line_burst_end ? spi_burst_pkg::WCNT_ZERO
                                             : spi_burst_pkg::words_after(s_q.cfg.burst_bit_count);
    if (master) begin
      if (!l_q.run && (l_q.sy2[spi_burst_pkg::LS_START] != l_q.start_seen)) begin
        l_d.run       = 1'b1;
        l_d.ssn       = 1'b0;
        l_d.need_load = 1'b1;
        l_d.got       = spi_burst_pkg::POS_ZERO;
        l_d.cur_len   = spi_burst_pkg::first_len(s_q.cfg.burst_bit_count);
        l_d.wleft     = spi_burst_pkg::words_after(s_q.cfg.burst_bit_count);
      end else if (l_q.run && l_q.need_load) begin
        // Stall the clock rather than resend: each posted word is taken once
        if (avail) begin
          l_d.tx_sh     = spi_burst_pkg::aligned(s_q.hold, l_q.cur_len);
          l_d.take_tgl  = !l_q.take_tgl;
          l_d.need_load = 1'b0;
        end
      end else if (l_q.run && !l_q.ph) begin
        l_d.ph    = 1'b1;
        l_d.sclk  = 1'b1;
        l_d.rx_sh = {l_q.rx_sh[spi_burst_pkg::WORD_W-2:0], spi_in.miso};
        l_d.got   = l_q.got + spi_burst_pkg::POS_ONE;
        bit_ev    = 1'b1;
      end else if (l_q.run) begin
        l_d.ph    = 1'b0;
        l_d.sclk  = 1'b0;
        l_d.tx_sh = l_q.tx_sh << 1;
        if (l_q.got == l_q.cur_len) begin
          l_d.rx_hold = spi_burst_pkg::low_bits(l_q.rx_sh, l_q.cur_len);
          l_d.rx_tgl  = !l_q.rx_tgl;
          l_d.got     = spi_burst_pkg::POS_ZERO;
          if (l_q.wleft == spi_burst_pkg::WCNT_ZERO) begin
            l_d.run      = 1'b0;
            l_d.ssn      = 1'b1;
            l_d.done_tgl = !l_q.done_tgl;
          end else begin
            l_d.wleft     = l_q.wleft - 1'b1;
            l_d.cur_len   = spi_burst_pkg::FULL_WORD;
            l_d.need_load = 1'b1;
          end
        end
      end
    end else if (!spi_in.ss_n) begin
      bit_ev = 1'b1;
      if (fresh_q) begin
        cl = base_len;
        wl = base_w;
        g1 = spi_burst_pkg::POS_ZERO;
      end
      g1          = g1 + spi_burst_pkg::POS_ONE;
      l_d.rx_sh   = {l_q.rx_sh[spi_burst_pkg::WORD_W-2:0], spi_in.mosi};
      l_d.tx_sh   = l_q.tx_sh << 1;
      l_d.got     = g1;
      l_d.cur_len = cl;
      l_d.wleft   = wl;
      if (g1 == cl) begin
        // Bits above the word length cleared, so an earlier frame never leaks in
        l_d.rx_hold = spi_burst_pkg::low_bits(l_d.rx_sh, cl);
        l_d.rx_tgl  = !l_q.rx_tgl;
        l_d.got     = spi_burst_pkg::POS_ZERO;
        if (wl == spi_burst_pkg::WCNT_ZERO) begin
          next_len = base_len;
          next_w   = base_w;
        end else begin
          next_w = wl - 1'b1;
        end
        l_d.cur_len = next_len;
        l_d.wleft   = next_w;
        // Slave cannot stall: an empty hand-off sends zeros
        l_d.tx_sh   = avail ? spi_burst_pkg::aligned(s_q.hold, next_len) : spi_burst_pkg::WORD_ZERO;
        if (avail) l_d.take_tgl = !l_q.take_tgl;
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) l_q <= '{ssn: 1'b1, default: '0};
    else         l_q <= l_d;
  end

  always_comb begin
    spi_out         = '0;
    spi_out.sclk    = l_q.sclk;
    spi_out.sclk_oe = master;
    spi_out.mosi    = l_q.tx_sh[spi_burst_pkg::WORD_W-1];
    spi_out.mosi_oe = master;
    spi_out.miso    = l_q.tx_sh[spi_burst_pkg::WORD_W-1];
    spi_out.miso_oe = !master && !spi_in.ss_n;
    spi_out.ss_n    = l_q.ssn;
    spi_out.ss_n_oe = master;
  end

  // Assertion helpers: bits and words per master burst
  logic [spi_burst_pkg::LEN_W:0]  h_bits_q;
  logic [spi_burst_pkg::WCNT_W:0] h_takes_q;
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      h_bits_q  <= '0;
      h_takes_q <= '0;
    end else if (master && !l_q.run) begin
      h_bits_q  <= '0;
      h_takes_q <= '0;
    end else begin
      h_bits_q  <= h_bits_q + (spi_burst_pkg::LEN_W+1)'(bit_ev);
      h_takes_q <= h_takes_q + (spi_burst_pkg::WCNT_W+1)'(l_d.take_tgl != l_q.take_tgl);
    end
  end

  a_slave_no_drive: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !s_q.cfg.channel_role_select |-> !spi_out.sclk_oe && !spi_out.ss_n_oe) else $error("slave drives clock");
  a_slave_count_end: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !master && bit_ev && !s_q.cfg.select_line_burst_end && fresh_q
    && (spi_burst_pkg::first_len(s_q.cfg.burst_bit_count) != spi_burst_pkg::POS_ONE
        || spi_burst_pkg::words_after(s_q.cfg.burst_bit_count) == spi_burst_pkg::WCNT_ZERO)
    |=> l_q.cur_len == spi_burst_pkg::first_len(s_q.cfg.burst_bit_count)) else $error("slave length wrong");
  a_select_word_len: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !master && bit_ev && s_q.cfg.select_line_burst_end |=> l_q.cur_len == spi_burst_pkg::FULL_WORD)
    else $error("select mode cut by count");
  a_select_no_words: assert property (@(posedge link_clk) disable iff (!lrst_n)
    !master && bit_ev && s_q.cfg.select_line_burst_end |=> l_q.wleft == spi_burst_pkg::WCNT_ZERO)
    else $error("count used in select mode");
  a_partial_stored: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(s_q.cap_pend) |-> ##[1:8] !s_q.cap_pend) else $error("partial word not stored");
  a_master_bits: assert property (@(posedge link_clk) disable iff (!lrst_n)
    $rose(l_q.ssn) |-> h_bits_q == (spi_burst_pkg::LEN_W+1)'(s_q.cfg.burst_bit_count) + 1'b1)
    else $error("master burst length wrong");
  a_words_once: assert property (@(posedge link_clk) disable iff (!lrst_n)
    $rose(l_q.ssn)
    |-> h_takes_q == (spi_burst_pkg::WCNT_W+1)'(spi_burst_pkg::words_after(s_q.cfg.burst_bit_count)) + 1'b1)
    else $error("word count per burst wrong");
  a_read_count_step: assert property (@(posedge clock) disable iff (!rst_n)
    pop_ev |=> s_q.rdcnt == $past(s_q.rdcnt) + 1'b1 ##1 s_q.posted) else $error("read count step wrong");
  a_no_double_pop: assert property (@(posedge clock) disable iff (!rst_n)
    pop_ev |=> !pop_ev) else $error("word handed off twice");
  a_start_cause: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(s_q.busy) |-> $past(exchange_trigger) || $past(s_q.cfg.auto_start_on_write))
    else $error("start without trigger");
  a_second_full: assert property (@(posedge link_clk) disable iff (!lrst_n)
    master && l_q.run && l_d.need_load && !l_q.need_load |-> l_d.cur_len == spi_burst_pkg::FULL_WORD)
    else $error("later word not full");

  c_master_burst: cover property (@(posedge link_clk) disable iff (!lrst_n) $rose(l_q.ssn) && h_bits_q > 32);
  c_slave_cut:    cover property (@(posedge clock) disable iff (!rst_n) s_q.cap_pend && l_q.got != '0);
  c_dma_write:    cover property (@(posedge clock) disable iff (!rst_n) tx_push && s_q.busy);
  c_rx_full:      cover property (@(posedge clock) disable iff (!rst_n) push_ev && !push_ok);

endmodule

// >>> sim/spi_partner.sv
`timescale 1ns/1ps
module spi_partner (
  output logic                    link_clk,
  output spi_burst_pkg::spi_in_s  spi_in,
  input  wire spi_burst_pkg::spi_out_s spi_out,
  input  wire logic               free_run
);
  logic got_q[$];

  // Free running only while the block is master or in reset
  initial begin
    link_clk = 1'b0;
    spi_in   = 3'h1;
    #1.7;
    forever begin
      #3;
      if (free_run) begin
        link_clk = ~link_clk;
      end
    end
  end

  // No pull on the data line, so it keeps changing when not driven
  always @(negedge spi_out.sclk) begin
    spi_in.miso <= ~spi_in.miso;
  end

  always @(posedge spi_out.sclk) begin
    if (spi_out.ss_n === 1'b0) begin
      got_q.push_back(spi_out.mosi);
    end
  end

  // Acts as an external master; clock stands low outside the frame
  task automatic frame(input logic [63:0] v, input int n);
    // Free clock may have stopped high; park low so the first bit gets its rising edge
    link_clk = 1'b0;
    spi_in.ss_n = 1'b0;
    #10;
    for (int i = n - 1; i >= 0; i--) begin
      spi_in.mosi = v[i];
      #3 link_clk = 1'b1;
      #3 link_clk = 1'b0;
    end
    #10;
    spi_in.ss_n = 1'b1;
    spi_in.mosi = ~spi_in.mosi;
  endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                    clock, rstn, link_clk, exchange_trigger, free_run;
  logic                    tx_valid, tx_ready, rx_valid, rx_ready, tx_dma_req, busy, rx_overflow;
  spi_burst_pkg::cfg_s     cfg;
  logic [3:0]              tx_dma_level;
  logic [31:0]             tx_data, rx_data, seed, base;
  logic [7:0]              tx_fifo_read_count;
  spi_burst_pkg::spi_in_s  spi_in;
  spi_burst_pkg::spi_out_s spi_out;
  logic [31:0]             rxq[$], words[$];
  logic [63:0]             v;
  int                      bad_count, comparisons, i, j, n, rem, w, cnt, sel, bbc;

  spi_burst_controller u_spi_burst_controller (
    .clock(clock), .rstn(rstn), .link_clk(link_clk), .cfg(cfg), .exchange_trigger(exchange_trigger),
    .tx_dma_level(tx_dma_level), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .tx_dma_req(tx_dma_req), .busy(busy),
    .rx_overflow(rx_overflow), .tx_fifo_read_count(tx_fifo_read_count), .spi_in(spi_in), .spi_out(spi_out)
  );

  spi_partner u_partner (.link_clk(link_clk), .spi_in(spi_in), .spi_out(spi_out), .free_run(free_run));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      rxq.push_back(rx_data);
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Received piece: next w bits below position rem, right aligned
  function automatic logic [31:0] piece(input logic [63:0] x, input int r, input int wd);
    return 32'((x >> (r - wd)) & ~(64'hffffffffffffffff << wd));
  endfunction

  task automatic end_sim;
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic timed_out(input string what);
    $display("wrong value %s expected done seen timeout", what);
    bad_count++;
    end_sim();
  endtask

  task automatic push_word(input logic [31:0] wd);
    int k;
    @(posedge clock);
    tx_valid <= 1'b1;
    tx_data  <= wd;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (tx_ready === 1'b1) break;
    end
    tx_valid <= 1'b0;
    if (k == 50) timed_out("tx_ready");
  endtask

  task automatic wait_busy(input logic level);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge clock);
      if (busy === level) break;
    end
    if (k == 3000) timed_out("busy");
  endtask

  initial begin
    rstn = 1'b0;
    cfg = '{1'h1, 1'h0, 1'h0, 12'h000};
    exchange_trigger = 1'b0;
    tx_dma_level = 4'h0;
    tx_valid = 1'b0;
    tx_data = 32'h0;
    rx_ready = 1'b1;
    free_run = 1'b1;
    seed = 32'h2;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    check_bit("tx_dma_req", 1'b1, tx_dma_req);
    // Master bursts of 1, 33 and 65 bits; later words arrive mid-burst
    for (n = 0; n < 3; n++) begin
      cfg.burst_bit_count <= 12'(n * 32);
      words.delete();
      for (i = 0; i <= n; i++) begin
        seed = lfsr(seed);
        words.push_back(seed);
      end
      u_partner.got_q.delete();
      base = 32'(tx_fifo_read_count);
      push_word(words[0]);
      repeat (20) @(posedge clock);
      check_bit("busy before trigger", 1'b0, busy);
      @(posedge clock) exchange_trigger <= 1'b1;
      @(posedge clock) exchange_trigger <= 1'b0;
      wait_busy(1'b1);
      for (i = 1; i <= n; i++) push_word(words[i]);
      wait_busy(1'b0);
      check_word("bits sent", 32'(n * 32 + 1), 32'(u_partner.got_q.size()));
      if (u_partner.got_q.size() == n * 32 + 1) begin
        check_bit("first bit", words[0][0], u_partner.got_q[0]);
        for (j = 1; j <= n * 32; j++) begin
          check_bit("mosi bit", words[(j + 31) / 32][31 - (j - 1) % 32], u_partner.got_q[j]);
        end
      end
      check_word("read count", base + 32'(n + 1), 32'(tx_fifo_read_count));
    end
    // Auto start: a queue write alone starts a 32-bit burst
    cfg.auto_start_on_write <= 1'b1;
    cfg.burst_bit_count <= 12'h01f;
    seed = lfsr(seed);
    u_partner.got_q.delete();
    base = 32'(tx_fifo_read_count);
    repeat (4) @(posedge clock);
    push_word(seed);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check_word("auto bits", 32'h20, 32'(u_partner.got_q.size()));
    check_word("auto read count", base + 32'h1, 32'(tx_fifo_read_count));
    if (u_partner.got_q.size() == 32) begin
      for (j = 0; j < 32; j++) begin
        check_bit("auto bit", seed[31 - j], u_partner.got_q[j]);
      end
    end
    cfg.auto_start_on_write <= 1'b0;
    // Slave: count mode, then select mode cutting the burst short
    @(posedge clock);
    cfg.channel_role_select <= 1'b0;
    free_run <= 1'b0;
    for (cnt = 0; cnt < 3; cnt++) begin
      sel = (cnt == 0) ? 0 : 1;
      bbc = (cnt == 0) ? 23 : 3;
      n = (cnt == 0) ? 48 : ((cnt == 1) ? 13 : 45);
      seed = lfsr(seed);
      v[63:32] = seed;
      seed = lfsr(seed);
      v[31:0] = seed;
      @(posedge clock);
      cfg.select_line_burst_end <= sel[0];
      cfg.burst_bit_count <= 12'(bbc);
      repeat (10) @(posedge clock);
      rxq.delete();
      u_partner.frame(v, n);
      repeat (20) @(posedge clock);
      rem = n;
      while (rem > 0) begin
        w = (sel == 1) ? ((rem > 32) ? 32 : rem) : bbc + 1;
        if (rxq.size() == 0) begin
          check_word("rx words", 32'(w), 32'h0);
          rem = 0;
        end else begin
          check_word("rx word", piece(v, rem, w), rxq.pop_front());
          rem -= w;
        end
      end
      check_word("rx extra", 32'h0, 32'(rxq.size()));
    end
    check_bit("rx_overflow", 1'b0, rx_overflow);
    end_sim();
  end
endmodule
